// ===== barm_regs.vh
// Constants for the barrier arm controller: register map, fields, states and timing.
`ifndef BARM_REGS_VH
`define BARM_REGS_VH

// Clock rate and timing figures.
`define BARM_CLK_MHZ 25
`define BARM_DEBOUNCE_US 10000
`define BARM_SEC_US 1000000
`define BARM_AC_MAX_SEC 7'h7c

// Register byte addresses on the plain register port.
`define BARM_ADDR_W 8
`define BARM_REG_CTRL 8'h00
`define BARM_REG_STATUS 8'h04

// Control register layout: configuration switches and auto-close delay.
`define BARM_CTRL_W 15
`define BARM_CTRL_RESET 15'h0000
`define BARM_F_DIP_AC 0
`define BARM_F_DIP_HOLD 1
`define BARM_F_DIP_STEP 2
`define BARM_F_DIP_NOCNT 3
`define BARM_F_DIP_NOPAUSE 4
`define BARM_F_DIP_NOBRAKE 5
`define BARM_F_DIP_SLAVE 7
`define BARM_F_DELAY_LO 8
`define BARM_F_DELAY_HI 14

// Field input vector positions.
`define BARM_NIN 14
`define BARM_I_OPEN 0
`define BARM_I_CLOSE 1
`define BARM_I_STOP 2
`define BARM_I_SINGLE 3
`define BARM_I_REVERSE 4
`define BARM_I_HOLD 5
`define BARM_I_RLOOP 6
`define BARM_I_COBST 7
`define BARM_I_UPLIM 8
`define BARM_I_DNLIM 9
`define BARM_I_TRIPR 10
`define BARM_I_TRIPL 11
`define BARM_I_POPEN 12
`define BARM_I_PCLOSE 13

// Sequencer states.
`define BARM_ST_STOP 3'h0
`define BARM_ST_RAISE 3'h1
`define BARM_ST_UP 3'h2
`define BARM_ST_LOWER 3'h3
`define BARM_ST_DOWN 3'h4
`define BARM_ST_PAUSE 3'h5

// Single-button step codes.
`define BARM_STEP_OPEN 2'h0
`define BARM_STEP_STOP1 2'h1
`define BARM_STEP_CLOSE 2'h2

`endif

// ===== barm_debounce.v
// Two-flop synchroniser and per-bit debounce filter for the field inputs.
`timescale 1ns/1ps
`default_nettype none

module barm_debounce #(
	parameter WIDTH = 14,
	parameter CYCLES = 250000
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Raw and filtered inputs.
	input wire [WIDTH-1:0] raw,
	output wire [WIDTH-1:0] clean
);
	localparam CW = $clog2(CYCLES + 1);
	localparam integer LAST_I = CYCLES - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];

	reg [WIDTH-1:0] sync_a;
	reg [WIDTH-1:0] sync_b;

	always @(posedge clk) begin
		if (rst) begin
			sync_a <= {WIDTH{1'b0}};
			sync_b <= {WIDTH{1'b0}};
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg [CW-1:0] cnt;
			reg stb;
			// Each bit keeps its own filtered level so every flop has one driver.
			assign clean[i] = stb;
			// A new level is taken only after it has held for the full window.
			always @(posedge clk) begin
				if (rst) begin
					cnt <= {CW{1'b0}};
					stb <= 1'b0;
				end else if (sync_b[i] == stb) begin
					cnt <= {CW{1'b0}};
				end else if (cnt == LAST) begin
					cnt <= {CW{1'b0}};
					stb <= sync_b[i];
				end else begin
					cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	endgenerate
endmodule // barm_debounce

`default_nettype wire

// ===== barm_controller.v
// Barrier arm sequencer with configuration register, auto-close timer and pairing.
//
// What this block does
// - Switch one on, arm up, no open/reverse/obstruction: lower after set delay 0-124 s.
// - Switch two on: hold-open pulse raises arm, held until reset or next pulse.
// - Switch two on: open/reset counting of switch four is ignored.
// - Switch two off: arm stays up only while hold-open is asserted.
// - Switch three on: single-button steps open, stop, close, stop, repeating.
// - Switch three off: single-button opens, or closes when arm is fully up.
// - Switch four off: count opens; lower only after equally many resets.
// - Switch five off: reset loop during lowering pauses descent until it clears.
// - Switch five on: lowering continues despite an active reset loop.
// - On DC drives switch six on suppresses dynamic brake; off brakes normally.
// - Switch eight selects role: off stand-alone or master, on slave.
// - Every unit pulses its pairing outputs for one cycle as a raise or lower starts; a slave's filter drops pulses under DB_CYCLES.
// - Raise-direction current trip while raising reverses the arm.
// - Lower-direction current trip while lowering counts as obstruction and reverses.
// - Stop halts motor at once and clears the obstruction lockout.
// - Reverse input while lowering drives the arm back fully up.
// - Close-obstruction honoured only while lowering or paused in descent; stops and raises arm fully.
// - Run output is on exactly while the motor is driven either way.
`timescale 1ns/1ps
`default_nettype none
`include "barm_regs.vh"

module barm_controller #(
	parameter DB_CYCLES = `BARM_DEBOUNCE_US * `BARM_CLK_MHZ,
	parameter SEC_CYCLES = `BARM_SEC_US * `BARM_CLK_MHZ,
	parameter DC_DRIVE = 1
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Register port.
	input wire [`BARM_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Field commands.
	input wire in_open,
	input wire in_close,
	input wire in_stop,
	input wire in_single,
	input wire in_reverse,
	input wire in_hold_open,
	input wire in_reset_loop,
	input wire in_close_obstr,
	// Limit switches and current-sense trips.
	input wire up_limit_switch,
	input wire down_limit_switch,
	input wire trip_raise,
	input wire trip_lower,
	// Pairing terminals.
	input wire pair_open_in,
	input wire pair_close_in,
	output reg pair_open_out,
	output reg pair_close_out,
	// Motor stage.
	output reg motor_raise,
	output reg motor_lower,
	output reg brake,
	output reg run_out
);
	localparam TW = $clog2(SEC_CYCLES + 1);
	localparam integer SEC_LAST_I = SEC_CYCLES - 1;
	localparam [TW-1:0] SEC_LAST = SEC_LAST_I[TW-1:0];

	wire [`BARM_NIN-1:0] raw_in;
	wire [`BARM_NIN-1:0] db;
	reg [`BARM_NIN-1:0] db_prev;
	wire [`BARM_NIN-1:0] rise;
	wire [`BARM_NIN-1:0] fall;

	reg [`BARM_CTRL_W-1:0] ctrl;
	reg [2:0] state;
	reg [2:0] next_state;
	reg lockout;
	reg next_lockout;
	reg hold_latch;
	reg hold_prev;
	reg [1:0] step;
	reg [7:0] open_count;
	reg [TW-1:0] tick;
	reg [6:0] sec_cnt;

	wire dip_ac = ctrl[`BARM_F_DIP_AC];
	wire dip_hold = ctrl[`BARM_F_DIP_HOLD];
	wire dip_step = ctrl[`BARM_F_DIP_STEP];
	wire dip_nocnt = ctrl[`BARM_F_DIP_NOCNT];
	wire dip_nopause = ctrl[`BARM_F_DIP_NOPAUSE];
	wire dip_nobrake = ctrl[`BARM_F_DIP_NOBRAKE];
	wire slave = ctrl[`BARM_F_DIP_SLAVE];
	wire [6:0] ac_delay = ctrl[`BARM_F_DELAY_HI:`BARM_F_DELAY_LO];

	// Synchronise and debounce every field pin before the sequencer sees it.
	assign raw_in = {pair_close_in, pair_open_in, trip_lower, trip_raise,
		down_limit_switch, up_limit_switch, in_close_obstr, in_reset_loop,
		in_hold_open, in_reverse, in_single, in_stop, in_close, in_open};

	barm_debounce #(
		.WIDTH(`BARM_NIN),
		.CYCLES(DB_CYCLES)
	) u_debounce (
		.clk(clk),
		.rst(rst),
		.raw(raw_in),
		.clean(db)
	);

	always @(posedge clk) begin
		if (rst) begin
			db_prev <= {`BARM_NIN{1'b0}};
		end else begin
			db_prev <= db;
		end
	end

	assign rise = db & ~db_prev;
	assign fall = ~db & db_prev;

	wire at_up = db[`BARM_I_UPLIM];
	wire at_down = db[`BARM_I_DNLIM];
	wire rloop = db[`BARM_I_RLOOP];
	wire rev_in = db[`BARM_I_REVERSE];
	wire cobst_in = db[`BARM_I_COBST];

	// Hold-open: latched by pulses with switch two on, a plain level otherwise.
	wire hold_active = dip_hold ? hold_latch : db[`BARM_I_HOLD];
	wire hold_rise = hold_active & ~hold_prev;
	wire hold_fall = ~hold_active & hold_prev;

	always @(posedge clk) begin
		if (rst) begin
			hold_latch <= 1'b0;
			hold_prev <= 1'b0;
		end else begin
			hold_prev <= hold_active;
			if (!dip_hold) begin
				hold_latch <= 1'b0;
			end else if (rise[`BARM_I_HOLD]) begin
				hold_latch <= ~hold_latch;
			end else if (fall[`BARM_I_RLOOP]) begin
				hold_latch <= 1'b0;
			end
		end
	end

	// Single-button decoding; local open, close and single buttons are ignored on a slave unit, stop still acts.
	wire single_hit = rise[`BARM_I_SINGLE] & ~slave;
	wire single_open = single_hit & (dip_step ? (step == `BARM_STEP_OPEN) :
		~(state == `BARM_ST_UP));
	wire single_close = single_hit & (dip_step ? (step == `BARM_STEP_CLOSE) :
		(state == `BARM_ST_UP));
	wire single_stop = single_hit & dip_step & step[0];

	always @(posedge clk) begin
		if (rst) begin
			step <= `BARM_STEP_OPEN;
		end else if (single_hit && dip_step) begin
			step <= step + 2'h1;
		end
	end

	// Open/reset balance counting, only with both switch two and four off.
	wire counting = ~dip_hold & ~dip_nocnt;
	wire local_open = ~slave & (rise[`BARM_I_OPEN] | single_open | hold_rise);
	wire rl_release = fall[`BARM_I_RLOOP];
	wire count_inc = counting & local_open & (open_count != 8'hff);
	wire count_dec = counting & rl_release & (open_count != 8'h00);
	// A release that drains the count to zero, or any release without counting, closes.
	wire rl_close = rl_release & (~counting | (open_count <= 8'h01)) & ~count_inc;

	always @(posedge clk) begin
		if (rst) begin
			open_count <= 8'h00;
		end else if (!counting) begin
			open_count <= 8'h00;
		end else if (count_inc && !count_dec) begin
			open_count <= open_count + 8'h01;
		end else if (count_dec && !count_inc) begin
			open_count <= open_count - 8'h01;
		end
	end

	// Auto-close timer runs in whole seconds while the arm rests fully up.
	wire ac_arm = dip_ac & (state == `BARM_ST_UP) & ~lockout & ~hold_active &
		~db[`BARM_I_OPEN] & ~rev_in & ~cobst_in & (open_count == 8'h00);
	wire [6:0] delay_eff = (ac_delay > `BARM_AC_MAX_SEC) ? `BARM_AC_MAX_SEC : ac_delay;
	wire ac_fire = ac_arm & (sec_cnt >= delay_eff);

	always @(posedge clk) begin
		if (rst || !ac_arm) begin
			tick <= {TW{1'b0}};
			sec_cnt <= 7'h00;
		end else if (tick == SEC_LAST) begin
			tick <= {TW{1'b0}};
			if (sec_cnt != 7'h7f) begin
				sec_cnt <= sec_cnt + 7'h01;
			end
		end else begin
			tick <= tick + {{(TW-1){1'b0}}, 1'b1};
		end
	end

	// Command merge; a slave takes its open and close from the master.
	wire cmd_open = ~lockout & (slave ? rise[`BARM_I_POPEN] : local_open);
	wire cmd_close = ~lockout & ~hold_active & (slave ? rise[`BARM_I_PCLOSE] :
		(rise[`BARM_I_CLOSE] | single_close | hold_fall | rl_close | ac_fire));
	wire stop_any = db[`BARM_I_STOP] | single_stop;

	always @* begin
		next_state = state;
		next_lockout = lockout;
		if (stop_any) begin
			next_lockout = 1'b0;
			if (state != `BARM_ST_UP && state != `BARM_ST_DOWN) begin
				next_state = `BARM_ST_STOP;
			end
		end else begin
			case (state)
				`BARM_ST_RAISE: begin
					if (db[`BARM_I_TRIPR]) begin
						next_state = `BARM_ST_LOWER;
						next_lockout = 1'b1;
					end else if (at_up) begin
						next_state = `BARM_ST_UP;
					end else if (cmd_close) begin
						next_state = `BARM_ST_LOWER;
					end
				end
				`BARM_ST_LOWER: begin
					if (db[`BARM_I_TRIPL]) begin
						next_state = `BARM_ST_RAISE;
						next_lockout = 1'b1;
					end else if (cobst_in || rev_in) begin
						next_state = `BARM_ST_RAISE;
					end else if (at_down) begin
						next_state = `BARM_ST_DOWN;
					end else if (rloop && !dip_nopause) begin
						next_state = `BARM_ST_PAUSE;
					end else if (cmd_open) begin
						next_state = `BARM_ST_RAISE;
					end
				end
				`BARM_ST_PAUSE: begin
					if (cobst_in || rev_in || cmd_open) begin
						next_state = `BARM_ST_RAISE;
					end else if (!rloop || dip_nopause) begin
						next_state = `BARM_ST_LOWER;
					end
				end
				`BARM_ST_UP, `BARM_ST_DOWN, `BARM_ST_STOP: begin
					if (cmd_open && !at_up) begin
						next_state = `BARM_ST_RAISE;
					end else if (cmd_close && !at_down) begin
						next_state = `BARM_ST_LOWER;
					end
				end
				default: begin
					next_state = `BARM_ST_STOP;
				end
			endcase
		end
	end

	wire drive_up = (next_state == `BARM_ST_RAISE);
	wire drive_dn = (next_state == `BARM_ST_LOWER);

	// Motor, brake and pairing outputs are registered from the next state.
	always @(posedge clk) begin
		if (rst) begin
			state <= `BARM_ST_STOP;
			lockout <= 1'b0;
			motor_raise <= 1'b0;
			motor_lower <= 1'b0;
			run_out <= 1'b0;
			brake <= 1'b0;
			pair_open_out <= 1'b0;
			pair_close_out <= 1'b0;
		end else begin
			state <= next_state;
			lockout <= next_lockout;
			motor_raise <= drive_up;
			motor_lower <= drive_dn;
			run_out <= drive_up | drive_dn;
			// The brake only engages on a DC drive and never fights the motor.
			brake <= (DC_DRIVE != 0) & ~dip_nobrake & ~drive_up & ~drive_dn;
			pair_open_out <= drive_up & (state != `BARM_ST_RAISE);
			pair_close_out <= drive_dn & (state != `BARM_ST_LOWER) &
				(state != `BARM_ST_PAUSE);
		end
	end

	// Register port: control is read-write, status read-only, others read zero.
	always @(posedge clk) begin
		if (rst) begin
			ctrl <= `BARM_CTRL_RESET;
			reg_rdata <= 32'h00000000;
		end else begin
			if (reg_wr && reg_addr == `BARM_REG_CTRL) begin
				ctrl <= reg_wdata[`BARM_CTRL_W-1:0];
			end
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					`BARM_REG_CTRL: begin
						reg_rdata <= {17'h00000, ctrl};
					end
					`BARM_REG_STATUS: begin
						reg_rdata <= {7'h00, sec_cnt, open_count, step, hold_active,
							lockout, at_down, at_up, run_out, state};
					end
					default: begin
						reg_rdata <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule // barm_controller

`default_nettype wire

// ===== barm_controller_asserts.sv
// Port-level assertions for the barrier arm controller.
`timescale 1ns/1ps
`default_nettype none
module barm_controller_asserts #(
	parameter DB_CYCLES = 250000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Watched inputs.
	input wire logic in_stop,
	input wire logic up_limit_switch,
	input wire logic down_limit_switch,
	// Watched outputs.
	input wire logic pair_open_out,
	input wire logic pair_close_out,
	input wire logic motor_raise,
	input wire logic motor_lower,
	input wire logic brake,
	input wire logic run_out
);
	// A level held this long has cleared the filter and the sequencer has answered.
	localparam int LIM = DB_CYCLES + 7;
	int c_up = 0;
	int c_dn = 0;
	int c_st = 0;
	always @(posedge clk) begin
		c_up <= up_limit_switch ? c_up + 1 : 0;
		c_dn <= down_limit_switch ? c_dn + 1 : 0;
		c_st <= in_stop ? c_st + 1 : 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_run; run_out == (motor_raise | motor_lower); endproperty
	a_run: assert property (p_run) else $error("run output wrong");
	property p_brk; run_out |-> !brake; endproperty
	a_brk: assert property (p_brk) else $error("brake while driven");
	property p_popen; pair_open_out |-> motor_raise; endproperty
	a_popen: assert property (p_popen) else $error("open pulse without raise");
	property p_pclose; pair_close_out |-> motor_lower; endproperty
	a_pclose: assert property (p_pclose) else $error("close pulse without lower");
	property p_ppulse; pair_open_out |=> !pair_open_out; endproperty
	a_ppulse: assert property (p_ppulse) else $error("open pulse too long");
	property p_up; c_up >= LIM |-> !motor_raise; endproperty
	a_up: assert property (p_up) else $error("raising past up limit");
	property p_dn; c_dn >= LIM |-> !motor_lower; endproperty
	a_dn: assert property (p_dn) else $error("lowering past down limit");
	property p_stop; c_st >= LIM |-> !run_out; endproperty
	a_stop: assert property (p_stop) else $error("motor runs during stop");
	c_raise: cover property ($rose(motor_raise));
	c_lower: cover property ($rose(motor_lower));
	c_pause: cover property (motor_lower ##1 (!motor_lower && !down_limit_switch));
endmodule // barm_controller_asserts
bind barm_controller barm_controller_asserts #(.DB_CYCLES(DB_CYCLES)) u_chk (
	.clk(clk), .rst(rst), .in_stop(in_stop), .up_limit_switch(up_limit_switch),
	.down_limit_switch(down_limit_switch), .pair_open_out(pair_open_out),
	.pair_close_out(pair_close_out), .motor_raise(motor_raise),
	.motor_lower(motor_lower), .brake(brake), .run_out(run_out)
);
`default_nettype wire

// ===== barm_arm_model.sv
// Arm travel model that drives the limit switches from the motor commands.
`timescale 1ns/1ps
`default_nettype none
module barm_arm_model #(
	parameter TRAVEL = 100
) (
	// Clock.
	input wire logic clk,
	// Motor commands.
	input wire logic motor_raise,
	input wire logic motor_lower,
	// Limit switches.
	output logic up_limit_switch,
	output logic down_limit_switch
);
	// One step a cycle, so the limits lag the motor as real travel does.
	int pos = 0;
	always @(posedge clk) begin
		if (motor_raise && pos < TRAVEL) pos <= pos + 1;
		else if (motor_lower && pos > 0) pos <= pos - 1;
	end
	assign up_limit_switch = (pos == TRAVEL);
	assign down_limit_switch = (pos == 0);
endmodule // barm_arm_model
`default_nettype wire

// ===== barm_controller_tb.sv
// Self-checking testbench for the barrier arm controller.
`timescale 1ns/1ps
`default_nettype none
`include "barm_regs.vh"
module barm_controller_tb;
	logic clk = 0;
	logic rst = 1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [13:0] fin = 14'h0;
	logic [31:0] d;
	wire [31:0] reg_rdata;
	wire po, pc, mr, ml, brake, run, upl, dnl;
	int err_total = 0;
	int samples_checked = 0;
	int po_cnt = 0;
	int pc_cnt = 0;
	// Pairing pulses last one cycle, so they are counted rather than sampled.
	always @(posedge clk) begin
		if (po) po_cnt <= po_cnt + 1;
		if (pc) pc_cnt <= pc_cnt + 1;
	end
	barm_controller #(.DB_CYCLES(4), .SEC_CYCLES(10), .DC_DRIVE(1)) DUT (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_open(fin[0]), .in_close(fin[1]), .in_stop(fin[2]), .in_single(fin[3]),
		.in_reverse(fin[4]), .in_hold_open(fin[5]), .in_reset_loop(fin[6]),
		.in_close_obstr(fin[7]), .up_limit_switch(upl), .down_limit_switch(dnl),
		.trip_raise(fin[10]), .trip_lower(fin[11]), .pair_open_in(fin[12]),
		.pair_close_in(fin[13]), .pair_open_out(po), .pair_close_out(pc),
		.motor_raise(mr), .motor_lower(ml), .brake(brake), .run_out(run));
	barm_arm_model #(.TRAVEL(100)) u_arm (.clk(clk), .motor_raise(mr),
		.motor_lower(ml), .up_limit_switch(upl), .down_limit_switch(dnl));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	// Held well past the debounce span so the filter cannot swallow it.
	task automatic pulse(input int i);
		@(posedge clk);
		fin[i] <= 1;
		repeat (12) @(posedge clk);
		fin[i] <= 0;
		repeat (12) @(posedge clk);
	endtask
	task automatic wst(input logic [2:0] s);
		int n = 0;
		rd(`BARM_REG_STATUS);
		while (d[2:0] !== s && n < 300) begin
			rd(`BARM_REG_STATUS);
			n++;
		end
		chk(d[2:0], s);
	endtask
	task automatic t_regs;
		rd(`BARM_REG_CTRL);
		chk(d, 32'h0);
		wr(`BARM_REG_CTRL, 32'h0508);
		wr(8'h10, 32'h0001);
		rd(`BARM_REG_CTRL);
		chk(d, 32'h0508);
		rd(8'h10);
		chk(d, 32'h0);
	endtask
	task automatic t_count;
		wr(`BARM_REG_CTRL, 32'h0);
		pulse(`BARM_I_OPEN);
		pulse(`BARM_I_OPEN);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_RLOOP);
		rd(`BARM_REG_STATUS);
		chk({d[17:10], ml}, {8'h01, 1'b0});
		pulse(`BARM_I_RLOOP);
		wst(`BARM_ST_DOWN);
	endtask
	task automatic t_ac;
		int n = 0;
		wr(`BARM_REG_CTRL, 32'h0209);
		pulse(`BARM_I_OPEN);
		wait (!mr);
		while (!ml && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 18 && n <= 24, 1);
		wst(`BARM_ST_DOWN);
	endtask
	task automatic t_pause;
		wr(`BARM_REG_CTRL, 32'h0008);
		pulse(`BARM_I_OPEN);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_CLOSE);
		fin[`BARM_I_RLOOP] <= 1;
		repeat (12) @(posedge clk);
		rd(`BARM_REG_STATUS);
		chk({d[2:0], ml}, {`BARM_ST_PAUSE, 1'b0});
		fin[`BARM_I_RLOOP] <= 0;
		repeat (12) @(posedge clk);
		chk(ml, 1);
		pulse(`BARM_I_REVERSE);
		wst(`BARM_ST_UP);
		wr(`BARM_REG_CTRL, 32'h0018);
		pulse(`BARM_I_CLOSE);
		fin[`BARM_I_RLOOP] <= 1;
		repeat (12) @(posedge clk);
		chk(ml, 1);
		fin[`BARM_I_RLOOP] <= 0;
		wst(`BARM_ST_DOWN);
	endtask
	task automatic t_trip;
		wr(`BARM_REG_CTRL, 32'h0008);
		pulse(`BARM_I_OPEN);
		pulse(`BARM_I_TRIPR);
		chk(ml, 1);
		wst(`BARM_ST_DOWN);
		pulse(`BARM_I_STOP);
		pulse(`BARM_I_OPEN);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_CLOSE);
		pulse(`BARM_I_TRIPL);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_CLOSE);
		rd(`BARM_REG_STATUS);
		chk({d[6], ml}, 2'b10);
		pulse(`BARM_I_STOP);
		rd(`BARM_REG_STATUS);
		chk(d[6], 0);
		pulse(`BARM_I_CLOSE);
		wst(`BARM_ST_DOWN);
	endtask
	task automatic t_step;
		wr(`BARM_REG_CTRL, 32'h000c);
		pulse(`BARM_I_SINGLE);
		chk(mr, 1);
		repeat (20) @(posedge clk);
		pulse(`BARM_I_SINGLE);
		chk(run, 0);
		pulse(`BARM_I_SINGLE);
		chk(ml, 1);
		pulse(`BARM_I_SINGLE);
		chk(run, 0);
		wr(`BARM_REG_CTRL, 32'h0008);
		pulse(`BARM_I_SINGLE);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_SINGLE);
		chk(ml, 1);
		fin[`BARM_I_STOP] <= 1;
		repeat (12) @(posedge clk);
		chk(run, 0);
		fin[`BARM_I_STOP] <= 0;
		pulse(`BARM_I_CLOSE);
		wst(`BARM_ST_DOWN);
		chk(brake, 1);
		wr(`BARM_REG_CTRL, 32'h0028);
		repeat (2) @(posedge clk);
		chk(brake, 0);
	endtask
	task automatic t_hold;
		wr(`BARM_REG_CTRL, 32'h00000002);
		pulse(`BARM_I_HOLD);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_OPEN);
		pulse(`BARM_I_OPEN);
		rd(`BARM_REG_STATUS);
		chk({d[17:10], run}, 9'h000);
		pulse(`BARM_I_RLOOP);
		chk(ml, 1'b1);
		wst(`BARM_ST_DOWN);
		pulse(`BARM_I_HOLD);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_HOLD);
		chk(ml, 1'b1);
		wst(`BARM_ST_DOWN);
		wr(`BARM_REG_CTRL, 32'h00000008);
		fin[`BARM_I_HOLD] <= 1'b1;
		wst(`BARM_ST_UP);
		repeat (20) @(posedge clk);
		chk(run, 1'b0);
		fin[`BARM_I_HOLD] <= 1'b0;
		repeat (12) @(posedge clk);
		chk(ml, 1'b1);
		wst(`BARM_ST_DOWN);
	endtask
	task automatic t_cobst;
		pulse(`BARM_I_COBST);
		chk(run, 1'b0);
		pulse(`BARM_I_OPEN);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_CLOSE);
		pulse(`BARM_I_COBST);
		chk(mr, 1'b1);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_CLOSE);
		wst(`BARM_ST_DOWN);
	endtask
	task automatic t_pair;
		int p0 = po_cnt;
		int c0 = pc_cnt;
		wr(`BARM_REG_CTRL, 32'h00000088);
		pulse(`BARM_I_OPEN);
		chk(run, 1'b0);
		pulse(`BARM_I_POPEN);
		chk(mr, 1'b1);
		wst(`BARM_ST_UP);
		pulse(`BARM_I_PCLOSE);
		chk(ml, 1'b1);
		wst(`BARM_ST_DOWN);
		chk(po_cnt - p0, 32'h1);
		chk(pc_cnt - c0, 32'h1);
		wr(`BARM_REG_CTRL, 32'h00000008);
		pulse(`BARM_I_POPEN);
		chk(run, 1'b0);
	endtask
	task automatic give_verdict;
		$display("checked=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		t_regs;
		t_count;
		t_ac;
		t_pause;
		t_trip;
		t_step;
		t_hold;
		t_cobst;
		t_pair;
		give_verdict;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		give_verdict;
	end
endmodule // barm_controller_tb
`default_nettype wire
